// ### core/tcca_pkg.sv
// Package: register map, field layout and mode codes of the timer control block
package tcca_pkg;

  // ----------------------------------------------------------------
  // Register map (word byte addresses, 8-bit data in low lanes)
  // ----------------------------------------------------------------
  localparam logic [11:0] TCZ_IDX = 12'hf06;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTL0 = 16'h3c18;
  localparam logic [ADDR_W-1:0] ADDR_CTL1 = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_CNTH = 16'h0004;
  localparam logic [ADDR_W-1:0] ADDR_CNTL = 16'h0008;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 16'h000c;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 16'h0010;
  localparam logic [ADDR_W-1:0] ADDR_TSTAT = 16'h0014;
  localparam logic [ADDR_W-1:0] ADDR_EVT = 16'h0018;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int C0_MODE_TOP = 7;
  localparam int C0_IRQ_HI = 6;
  localparam int C0_IRQ_LO = 5;
  localparam int C0_DB_HI = 3;
  localparam int C0_DB_LO = 1;
  localparam int C0_CAP = 0;
  localparam int C1_EN = 7;
  localparam int C1_PRE_HI = 5;
  localparam int C1_PRE_LO = 3;
  localparam int C1_MODE_HI = 2;
  localparam int C1_MODE_LO = 0;
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL0_WMASK = 8'hfe;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam int IRQ_W = 3;
  localparam int IRQ_CAP = 2;
  localparam int IRQ_WRAP = 1;
  localparam int IRQ_RSVD = 0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_ONE_SHOT   = 4'b0000,
    MODE_CONTINUOUS = 4'b0001,
    MODE_COUNTER    = 4'b0010,
    MODE_PWM_SINGLE = 4'b0011,
    MODE_CAPTURE    = 4'b0100,
    MODE_GATED      = 4'b0110,
    MODE_CAP_CMP    = 4'b0111,
    MODE_PWM_DUAL   = 4'b1000,
    MODE_CAP_RESTART= 4'b1001,
    MODE_CMP_COUNTER= 4'b1010
  } tcca_mode_t;

  // Bus request carried as one bundle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } tcca_req_t;

endpackage

// ### core/tcca_prescale.sv
// Power-of-two prescaler producing a one-cycle count enable
`timescale 1ns/1ps
module tcca_prescale #(
  parameter int PRE_W = 3
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [PRE_W-1:0] exponent,
  output logic tick
);
  import tcca_pkg::*;

  localparam int DIV_W = (1 << PRE_W) - 1;

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic [DIV_W-1:0] limit;
  logic tick_next;

  // Terminal count is 2**exponent - 1; divide by 1 gives a tick every cycle
  assign limit = DIV_W'((1 << exponent) - 1);
  assign tick_next = enable && (div_reg >= limit);
  // Disabled timer holds the divider at zero for a clean restart
  assign div_next = !enable ? '0 : (tick_next ? '0 : DIV_W'(div_reg + 1'b1));

  // ----------------------------------------------------------------
  // Divider register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick <= tick_next;
    end
  end

  chk_clear_when_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !enable |=> (div_reg == '0) && !tick)
    else $error("prescaler not cleared while disabled");

  // Divide by four: divider walks 0..3, the registered tick shows one edge later
  chk_div_ratio: assert property (@(posedge mclk) disable iff (!rst_n)
    (enable && exponent == 3'd2 && $stable(exponent) && div_reg == '0 && $past(enable))
      ##1 (enable && exponent == 3'd2) [*3] |=> tick)
    else $error("prescaler ratio wrong");
endmodule

// ### core/tcca_timer.sv
// Timer control registers, count access latch, prescaler and interrupt status
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module tcca_timer #(
  parameter int CNT_W = 16,
  parameter int PRE_W = 3
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [tcca_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer_pin_in,
  input wire logic capture_event,
  input wire logic alt_func_sel,
  output logic timer_in_used,
  output logic [3:0] mode_code,
  output logic [2:0] deadband_delay,
  output logic [1:0] irq_config,
  output logic mode_reserved,
  output logic irq
);
  import tcca_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] ctl0_reg;
  logic [7:0] ctl1_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [7:0] hold_reg;
  logic [IRQ_W-1:0] stat_reg;
  logic [IRQ_W-1:0] stat_next;
  logic [IRQ_W-1:0] mask_reg;
  logic [IRQ_W-1:0] evt_set;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_d_reg;
  logic cap_s1_reg;
  logic cap_s2_reg;
  logic cap_d_reg;
  logic tick;
  logic enabled;
  logic [3:0] mode_w;
  logic rsvd_w;
  logic dual_pwm;
  logic cap_mode;
  logic edge_in;
  logic cap_pulse;
  logic wrap;
  tcca_req_t req;
  logic acc;
  logic wr_ok;
  logic rd_ok;
  logic sel_c0;
  logic sel_c1;
  logic sel_ch;
  logic sel_cl;
  logic sel_st;
  logic sel_mk;
  logic sel_ts;
  logic sel_ev;
  logic [7:0] low_view;

  // Reserved codes: 0101 and anything above 1010
  function automatic logic mode_is_rsvd(input logic [3:0] m);
    mode_is_rsvd = (m == 4'b0101) || (m > MODE_CMP_COUNTER);
  endfunction

  // Modes that react to an input capture edge
  function automatic logic mode_captures(input logic [3:0] m);
    mode_captures = (m == MODE_CAPTURE) || (m == MODE_CAP_CMP)
      || (m == MODE_CAP_RESTART);
  endfunction

  // ----------------------------------------------------------------
  // Request bundle and address decode
  // ----------------------------------------------------------------
  assign req = '{rd: avs_read, wr: avs_write, addr: avs_address,
    wdata: avs_writedata[7:0]};
  // One wait cycle per access; the access commits on the ack edge only
  assign acc = (req.rd || req.wr) && !ack_reg;
  assign wr_ok = acc && req.wr && avs_byteenable[0];
  assign rd_ok = acc && req.rd;
  assign sel_c0 = (req.addr == ADDR_CTL0);
  assign sel_c1 = (req.addr == ADDR_CTL1);
  assign sel_ch = (req.addr == ADDR_CNTH);
  assign sel_cl = (req.addr == ADDR_CNTL);
  assign sel_st = (req.addr == ADDR_STAT);
  assign sel_mk = (req.addr == ADDR_MASK);
  assign sel_ts = (req.addr == ADDR_TSTAT);
  assign sel_ev = (req.addr == ADDR_EVT);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign mode_w = {ctl0_reg[C0_MODE_TOP], ctl1_reg[C1_MODE_HI:C1_MODE_LO]};
  assign rsvd_w = mode_is_rsvd(mode_w);
  assign dual_pwm = (mode_w == MODE_PWM_DUAL);
  assign cap_mode = mode_captures(mode_w);
  assign enabled = ctl1_reg[C1_EN];

  // ----------------------------------------------------------------
  // Pin synchronisers; edge detect reads only the second stage onward
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg <= 1'b0;
      cap_s1_reg <= 1'b0;
      cap_s2_reg <= 1'b0;
      cap_d_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= timer_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
      cap_s1_reg <= capture_event;
      cap_s2_reg <= cap_s1_reg;
      cap_d_reg <= cap_s2_reg;
    end
  end

  // Dual-output PWM gives the shared pin to the complementary output
  assign edge_in = alt_func_sel && !dual_pwm && pin_s2_reg && !pin_d_reg;
  assign cap_pulse = enabled && cap_mode && cap_s2_reg && !cap_d_reg;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  tcca_prescale #(.PRE_W(PRE_W)) u_pre (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(enabled),
    .exponent(ctl1_reg[C1_PRE_HI:C1_PRE_LO]),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Counter: counter mode counts pin edges, reserved codes hold the count, others count prescaled ticks
  // ----------------------------------------------------------------
  assign wrap = enabled && (count_reg == '1)
    && ((mode_w == MODE_COUNTER) ? edge_in : tick);
  always_comb
  begin
    count_next = count_reg;
    if (enabled && !rsvd_w && ((mode_w == MODE_COUNTER) ? edge_in : tick))
      count_next = CNT_W'(count_reg + 1'b1);
    // Software write wins over the count step, no write holding register
    if (wr_ok && sel_ch)
      count_next = {req.wdata, count_next[7:0]};
    if (wr_ok && sel_cl)
      count_next = {count_next[CNT_W-1:8], req.wdata};
  end

  // ----------------------------------------------------------------
  // Control, count, holding and status registers
  // ----------------------------------------------------------------
  assign evt_set = {cap_pulse, wrap && !rsvd_w, 1'b0};
  // Set beats a write-one clear in the same cycle
  assign stat_next = (stat_reg & ~((wr_ok && sel_st) ? req.wdata[IRQ_W-1:0] : '0))
    | evt_set;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl0_reg <= CTL0_RST;
      ctl1_reg <= CTL1_RST;
      count_reg <= CNT_RST;
      hold_reg <= CNT_RST[7:0];
      stat_reg <= '0;
      mask_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
      stat_reg <= stat_next;
      // Capture flag: set by capture interrupt, cleared by any other
      if (cap_pulse)
        ctl0_reg[C0_CAP] <= 1'b1;
      else if (wrap && !rsvd_w)
        ctl0_reg[C0_CAP] <= 1'b0;
      if (wr_ok && sel_c0)
        ctl0_reg[7:1] <= req.wdata[7:1];
      if (wr_ok && sel_c1)
        ctl1_reg <= req.wdata;
      if (wr_ok && sel_mk)
        mask_reg <= req.wdata[IRQ_W-1:0];
      if (rd_ok && sel_ch && enabled)
        hold_reg <= count_reg[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  assign low_view = enabled ? hold_reg : count_reg[7:0];
  always_comb
  begin
    rdata_next = UNMAPPED_DATA;
    if (sel_c0)
      rdata_next = {24'h000000, ctl0_reg};
    else if (sel_c1)
      rdata_next = {24'h000000, ctl1_reg};
    else if (sel_ch)
      rdata_next = {24'h000000, count_reg[CNT_W-1:8]};
    else if (sel_cl)
      rdata_next = {24'h000000, low_view};
    else if (sel_st)
      rdata_next = {29'h0, stat_reg};
    else if (sel_mk)
      rdata_next = {29'h0, mask_reg};
    else if (sel_ts)
      rdata_next = {26'h0, rsvd_w, dual_pwm, mode_w};
    else if (sel_ev)
      rdata_next = {29'h0, evt_set};
  end

  // ----------------------------------------------------------------
  // Bus answer and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      timer_in_used <= 1'b0;
      mode_code <= 4'h0;
      deadband_delay <= 3'h0;
      irq_config <= 2'h0;
      mode_reserved <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      ack_reg <= acc;
      avs_waitrequest <= !acc;
      if (rd_ok)
        avs_readdata <= rdata_next;
      timer_in_used <= alt_func_sel && !dual_pwm;
      mode_code <= mode_w;
      deadband_delay <= ctl0_reg[C0_DB_HI:C0_DB_LO];
      irq_config <= ctl0_reg[C0_IRQ_HI:C0_IRQ_LO];
      mode_reserved <= rsvd_w;
      irq <= |(stat_next & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mode_concat: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 mode_code == {$past(ctl0_reg[C0_MODE_TOP]), $past(ctl1_reg[C1_MODE_HI:C1_MODE_LO])})
    else $error("mode code not formed from control bits");
  chk_hold_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_ok && sel_ch && enabled) |=> hold_reg == $past(count_reg[7:0]))
    else $error("holding register missed high read");
  chk_low_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_ok && sel_cl && enabled) |=> avs_readdata[7:0] == $past(hold_reg))
    else $error("enabled low read not from holding");
  chk_low_live: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_ok && sel_cl && !enabled) |=> avs_readdata[7:0] == $past(count_reg[7:0]))
    else $error("disabled low read not live");
  chk_count_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ok && sel_ch) |=> count_reg[CNT_W-1:8] == $past(req.wdata))
    else $error("high byte write not loaded");
  chk_cap_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    cap_pulse |=> ctl0_reg[C0_CAP] ##1 (ctl0_reg[C0_CAP] || $past(wrap)))
    else $error("capture flag not set");
  chk_cap_ro: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ok && sel_c0 && !cap_pulse && !wrap) |=> $stable(ctl0_reg[C0_CAP]))
    else $error("capture flag written by software");
  chk_pin_dual: assert property (@(posedge mclk) disable iff (!rst_n)
    dual_pwm |=> !timer_in_used)
    else $error("timer input active in dual pwm");
  chk_rsvd_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode_w == 4'b0101) |=> mode_reserved)
    else $error("reserved mode not flagged");
  chk_bus_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    (acc) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  chk_bus_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (!avs_read && !avs_write) |=> avs_waitrequest)
    else $error("bus answered without a request");

  // ----------------------------------------------------------------
  // Count, flag and interrupt checks
  // ----------------------------------------------------------------
  // A low byte write lands whole; only the high byte keeps the step
  chk_low_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ok && sel_cl) |=> count_reg[7:0] == $past(req.wdata))
    else $error("low byte write not loaded");
  // One prescaled tick adds exactly one in the tick-driven modes
  chk_count_step: assert property (@(posedge mclk) disable iff (!rst_n)
    (enabled && !rsvd_w && (mode_w != MODE_COUNTER) && tick && !wr_ok)
      |=> count_reg == CNT_W'($past(count_reg) + 1'b1))
    else $error("count step wrong");
  // Without the pin function the counter mode sees no edges at all
  chk_pin_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    (enabled && (mode_w == MODE_COUNTER) && !alt_func_sel && !wr_ok) |=> $stable(count_reg))
    else $error("counter moved without pin function");
  chk_wrap_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrap && !rsvd_w && !cap_pulse) |=> !ctl0_reg[C0_CAP])
    else $error("capture flag kept after wrap interrupt");
  // Reserved codes freeze the count; only a software write may move it
  chk_rsvd_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    (rsvd_w && !wr_ok) |=> $stable(count_reg))
    else $error("count moved in reserved mode");
  // A new event is never lost to a write-one clear in the same cycle
  chk_stat_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_set[IRQ_CAP] |=> stat_reg[IRQ_CAP])
    else $error("capture status bit lost");
  // A mask write reaches the pin one edge late, so only a steady mask counts
  chk_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
    ((|(stat_reg & mask_reg)) && $stable(mask_reg)) |-> irq)
    else $error("interrupt low while unmasked status set");
endmodule

// ### testbench/timer_control_and_count_access_test.sv
// Self-checking testbench for the timer control and count access block
`timescale 1ns/1ps
module timer_control_and_count_access_test;
  import tcca_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic capture_event = 1'b0;
  logic timer_pin_in = 1'b0;
  logic alt_func_sel = 1'b1;
  logic timer_in_used, mode_reserved, irq;
  logic [3:0] mode_code;
  logic [2:0] deadband_delay;
  logic [1:0] irq_config;
  int n_mismatch = 0;
  int num_checks = 0;

  tcca_timer tcca_timer_i (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_pin_in(timer_pin_in), .capture_event(capture_event), .alt_func_sel(alt_func_sel),
    .timer_in_used(timer_in_used), .mode_code(mode_code), .deadband_delay(deadband_delay),
    .irq_config(irq_config), .mode_reserved(mode_reserved), .irq(irq));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    @(posedge mclk);
    // Only the watchdog ends a wait that never sees the answer
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Idle edge so a following call never re-raises a strobe in this time step
    @(posedge mclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask

  task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] q;
    rd(a, q);
    chk(nm, exp, q);
  endtask

  // Stop the timer and clear both count bytes
  task automatic zero_count();
    wr(ADDR_CTL1, 8'h00);
    wr(ADDR_CNTH, 8'h00);
    wr(ADDR_CNTL, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_fields();
    rd_chk("ctl0 reset", ADDR_CTL0, CTL0_RST);
    rd_chk("ctl1 reset", ADDR_CTL1, CTL1_RST);
    wr(ADDR_CTL0, 8'hff);
    rd_chk("ctl0 capture bit read only", ADDR_CTL0, 8'hfe);
    wr(ADDR_CTL0, 8'h6e);
    rd_chk("ctl0 readback", ADDR_CTL0, 8'h6e);
    chk("deadband", 8'h07, {5'h0, deadband_delay});
    chk("irq config", 8'h03, {6'h0, irq_config});
    wr(ADDR_CTL1, 8'h5a);
    rd_chk("ctl1 readback", ADDR_CTL1, 8'h5a);
    rd_chk("unmapped read", 16'h0100, 8'h00);
  endtask

  // Every 4-bit code: ordering of the bits, reserved codes, pin role
  task automatic t_modes();
    logic [3:0] m;
    for (int i = 0; i < 16; i++)
    begin
      m = i[3:0];
      wr(ADDR_CTL0, {m[3], 7'h00});
      wr(ADDR_CTL1, {5'h00, m[2:0]});
      @(posedge mclk);
      chk("mode code", {4'h0, m}, {4'h0, mode_code});
      chk("mode reserved", {7'h0, (m == 4'h5 || m > 4'ha)}, {7'h0, mode_reserved});
      chk("pin as input", {7'h0, (m != MODE_PWM_DUAL)}, {7'h0, timer_in_used});
    end
    wr(ADDR_CTL0, 8'h00);
  endtask

  // Elapsed count over a fixed span for each prescale exponent
  task automatic t_prescale();
    logic [7:0] h, l;
    int c, e;
    for (int p = 0; p < 8; p++)
    begin
      zero_count();
      wr(ADDR_CTL1, {2'b10, p[2:0], 3'b001});
      repeat (1024) @(posedge mclk);
      wr(ADDR_CTL1, 8'h00);
      rd(ADDR_CNTH, h);
      rd(ADDR_CNTL, l);
      c = {h, l};
      e = 1024 >> p;
      num_checks++;
      if (c < e - 1 || c > e + 4)
      begin
        n_mismatch++;
        $display("MISMATCH prescale %0d expected %0d seen %0d", p, e, c);
      end
    end
  endtask

  // Two short runs must each start from a cleared prescaler
  task automatic t_prescale_clear();
    logic [7:0] c1, c2;
    zero_count();
    // Divide by 64 for about 100 cycles: one tick per run from a clean start
    wr(ADDR_CTL1, 8'hb1);
    repeat (100) @(posedge mclk);
    wr(ADDR_CTL1, 8'h00);
    rd(ADDR_CNTL, c1);
    wr(ADDR_CTL1, 8'hb1);
    repeat (100) @(posedge mclk);
    wr(ADDR_CTL1, 8'h00);
    rd(ADDR_CNTL, c2);
    chk("count after two short runs", c1 << 1, c2);
  endtask

  // Live writes, coherent high/low reads and direct reads when stopped
  task automatic t_count_access();
    logic [7:0] x1, x2, x3;
    zero_count();
    wr(ADDR_CTL1, 8'h81);
    wr(ADDR_CNTH, 8'hab);
    rd_chk("high byte after live write", ADDR_CNTH, 8'hab);
    rd(ADDR_CNTL, x1);
    repeat (20) @(posedge mclk);
    rd(ADDR_CNTL, x2);
    chk("low byte from holding", x1, x2);
    rd_chk("high byte still", ADDR_CNTH, 8'hab);
    rd(ADDR_CNTL, x3);
    num_checks++;
    if (x3 === x1 || $isunknown(x3))
    begin
      n_mismatch++;
      $display("MISMATCH holding refresh expected change from %h seen %h", x1, x3);
    end
    wr(ADDR_CTL1, 8'h00);
    wr(ADDR_CNTL, 8'h5a);
    rd_chk("low byte direct when stopped", ADDR_CNTL, 8'h5a);
  endtask

  // Capture sets the flag and raises a maskable, clearable interrupt
  task automatic t_capture_irq();
    zero_count();
    wr(ADDR_CTL1, 8'h84);
    capture_event <= 1'b1;
    repeat (5) @(posedge mclk);
    capture_event <= 1'b0;
    repeat (6) @(posedge mclk);
    rd_chk("capture flag", ADDR_CTL0, 8'h01);
    rd_chk("irq status", ADDR_STAT, 8'h04);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(ADDR_MASK, 8'h04);
    @(posedge mclk);
    chk("irq unmasked", 8'h01, {7'h0, irq});
    wr(ADDR_STAT, 8'h04);
    @(posedge mclk);
    chk("irq after clear", 8'h00, {7'h0, irq});
    rd_chk("status after clear", ADDR_STAT, 8'h00);
    // Preset near the top so a wrap interrupt follows within a few cycles
    wr(ADDR_CTL1, 8'h00);
    wr(ADDR_CNTH, 8'hff);
    wr(ADDR_CNTL, 8'hf0);
    wr(ADDR_CTL1, 8'h81);
    repeat (30) @(posedge mclk);
    rd_chk("capture flag cleared by wrap", ADDR_CTL0, 8'h00);
    rd_chk("wrap status", ADDR_STAT, 8'h02);
    chk("wrap masked", 8'h00, {7'h0, irq});
    wr(ADDR_CTL1, 8'h00);
  endtask

  // Counter mode counts pin edges only while the pin function is selected
  task automatic t_pin_count();
    zero_count();
    wr(ADDR_CTL1, 8'h82);
    for (int k = 0; k < 5; k++)
    begin
      timer_pin_in <= 1'b1;
      repeat (4) @(posedge mclk);
      timer_pin_in <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    alt_func_sel <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("pin deselected", 8'h00, {7'h0, timer_in_used});
    timer_pin_in <= 1'b1;
    repeat (4) @(posedge mclk);
    timer_pin_in <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(ADDR_CTL1, 8'h00);
    rd_chk("pin edges counted", ADDR_CNTL, 8'h05);
    alt_func_sel <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset_and_fields();
    t_modes();
    t_prescale();
    t_prescale_clear();
    t_count_access();
    t_pin_count();
    t_capture_irq();
    wrap_up();
  end

  // Whole run needs about 9000 cycles; a hang is cut well beyond that
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
